// file: protocol_sequence_call_unit.sv
`include "pscu_cfg.svh"
module protocol_sequence_call_unit (
  input wire logic CLK_I, // system clock
  input wire logic RST_I, // sync reset, high
  input wire logic CE_I, // clock enable
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb enable
  input wire logic PWRITE_I, // apb direction
  input wire logic [15:0] PADDR_I, // apb byte address
  input wire logic [31:0] PWDATA_I, // apb write data
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error
  output logic [1:0] LINK_START_O, // sequence start per port
  output logic [9:0] LINK_SEQ_O, // sequence number
  output logic [1:0] LINK_TX_VALID_O, // send word strobe per port
  output logic [15:0] LINK_TX_DATA_O, // send word
  input wire logic [1:0] LINK_RX_VALID_I, // receive word strobe
  input wire logic [15:0] LINK_RX_DATA_I, // receive word
  input wire logic [1:0] LINK_STEP_ERR_I, // step failed
  input wire logic [1:0] LINK_DONE_I, // sequence ended normally
  input wire logic [1:0] LINK_FAIL_I // sequence ended in error
);
  import pscu_pkg::*;

  // ==========================================
  // helpers
  function automatic logic bcd_ok(input logic [15:0] v);
    return v[3:0] < 4'hA && v[7:4] < 4'hA && v[11:8] < 4'hA && v[15:12] < 4'hA;
  endfunction

  function automatic logic [13:0] bcd_bin(input logic [15:0] v);
    return 14'(v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]);
  endfunction

  function automatic logic [15:0] bin_bcd(input logic [8:0] n);
    return {4'h0, 4'(n / 100), 4'((n / 10) % 10), 4'(n % 10)};
  endfunction

  // returns {in bounds and BCD, word address}
  function automatic logic [13:0] locate(input logic [17:0] op, input logic [15:0] ptr);
    logic [13:0] a;
    logic [13:0] b;
    a = bcd_bin(op[15:0]);
    b = bcd_bin(ptr);
    if (op[`OP_IND]) begin
      return {bcd_ok(op[15:0]) && a < `MEM_WORDS && bcd_ok(ptr) && b < `MEM_WORDS, b[12:0]};
    end
    return {bcd_ok(op[15:0]) && a < `MEM_WORDS, a[12:0]};
  endfunction

  // ==========================================
  // storage
  state_type state;
  state_type next_state;
  logic [15:0] mem [0:8191];
  logic mem_we;
  logic [12:0] mem_wa;
  logic [15:0] mem_wd;

  // ==========================================
  // call operand checks
  logic [13:0] s_pi;
  logic [13:0] d_pi;
  logic [15:0] s_ptr;
  logic [15:0] d_ptr;
  logic [13:0] s_loc;
  logic [13:0] d_loc;
  logic [15:0] cnt_word;
  logic [13:0] cnt;
  logic s_none;
  logic s_bad;
  logic d_bad;
  logic p_ok;
  logic seq_ok;
  logic wr_ok;
  logic call;
  logic call_ok;
  logic hit;

  // pointer words and send count are fetched before any transfer
  assign s_pi = bcd_bin(state.s_op[15:0]);
  assign d_pi = bcd_bin(state.d_op[15:0]);
  assign s_ptr = mem[s_pi[12:0]];
  assign d_ptr = mem[d_pi[12:0]];
  assign s_loc = locate(state.s_op, s_ptr);
  assign d_loc = locate(state.d_op, d_ptr);
  assign cnt_word = mem[s_loc[12:0]];
  assign cnt = bcd_bin(cnt_word);
  assign s_none = state.s_op[`OP_CONST] && state.s_op[15:0] == 16'h0000;
  // count includes itself and must fit memory
  assign s_bad = state.s_op[`OP_CONST] ? !s_none :
    (!s_loc[13] || !bcd_ok(cnt_word) || cnt == 14'h0000 || cnt > `CNT_MAX ||
     {1'b0, s_loc[12:0]} + cnt > `MEM_WORDS);
  assign d_bad = state.d_op[`OP_CONST] || !d_loc[13] ||
    (d_loc[12:0] >= `RSV_LO && d_loc[12:0] <= `RSV_HI);
  assign p_ok = PWDATA_I[15:12] == `PORT_A || PWDATA_I[15:12] == `PORT_B;
  assign seq_ok = bcd_ok({4'h0, PWDATA_I[11:0]});
  assign wr_ok = PSEL_I && PENABLE_I && PWRITE_I && state.pready && !state.pslverr;
  assign call = wr_ok && PADDR_I == `A_CALL;
  assign call_ok = !(|state.exec) && p_ok && seq_ok && !s_bad && !d_bad;
  assign hit = PADDR_I[15] || (PADDR_I[14:0] <= 15'h0010 && PADDR_I[1:0] == 2'h0);

  // ==========================================
  // next state
  always_comb begin
    logic [31:0] rd;
    logic p;
    rd = 32'h0000_0000;
    p = state.port;
    next_state = state;
    mem_we = 1'b0;
    mem_wa = 13'h0000;
    mem_wd = 16'h0000;
    next_state.start = 2'h0;
    next_state.tx_valid = 2'h0;
    next_state.pready = 1'b0;
    // apb read mux, answered in the access phase
    if (PADDR_I[15]) begin
      rd = {16'h0000, mem[PADDR_I[14:2]]};
    end else begin
      unique case (PADDR_I[4:0])
        5'h00: rd = {16'h0000, state.ctrl};
        5'h04: rd = {14'h0000, state.s_op};
        5'h08: rd = {14'h0000, state.d_op};
        5'h0C: rd = {23'h000000, state.op_err, state.seq_abort[1], state.seq_end[1],
                     state.step_err[1], state.exec[1], state.seq_abort[0], state.seq_end[0],
                     state.step_err[0], state.exec[0]};
        5'h10: rd = {30'h00000000, state.abort_req};
        default: rd = 32'h0000_0000;
      endcase
    end
    if (PSEL_I && !PENABLE_I) begin
      next_state.pready = 1'b1;
      next_state.pslverr = !hit;
      next_state.prdata = hit ? rd : 32'h0000_0000;
    end
    // apb register writes
    if (wr_ok) begin
      if (PADDR_I[15]) begin
        mem_we = 1'b1;
        mem_wa = PADDR_I[14:2];
        mem_wd = PWDATA_I[15:0];
      end
      if (PADDR_I == `A_SOP) next_state.s_op = PWDATA_I[17:0];
      if (PADDR_I == `A_DOP) next_state.d_op = PWDATA_I[17:0];
      if (PADDR_I == `A_ABORT) next_state.abort_req = PWDATA_I[1:0];
    end
    // sequencer
    unique case (state.phase)
      ST_IDLE: begin
      end
      ST_SEND: begin
        next_state.tx_valid[p] = 1'b1;
        next_state.tx_data = mem[13'(state.s_addr + 13'(state.tx_idx) + 13'h0001)];
        next_state.tx_idx = state.tx_idx + 9'h001;
        next_state.tx_left = state.tx_left - 9'h001;
        if (state.tx_left == 9'h001) next_state.phase = ST_WAIT;
      end
      ST_WAIT: begin
        // data words go after the count word, excess dropped
        if (LINK_RX_VALID_I[p] && state.rx_n < `RX_MAX) begin
          if ({1'b0, state.d_addr} + 14'(state.rx_n) + 14'h0001 < `MEM_WORDS) begin
            mem_we = 1'b1;
            mem_wa = 13'(state.d_addr + 13'(state.rx_n) + 13'h0001);
            mem_wd = LINK_RX_DATA_I;
          end
          next_state.rx_n = state.rx_n + 9'h001;
        end
        if (LINK_DONE_I[p] || LINK_FAIL_I[p]) begin
          next_state.fail = LINK_FAIL_I[p];
          if (state.rx_n != 9'h000) begin
            next_state.phase = ST_STORE;
          end else begin
            // nothing received: destination stays untouched
            next_state.phase = ST_IDLE;
            next_state.exec[p] = 1'b0;
            next_state.seq_end[p] = !LINK_FAIL_I[p];
            next_state.seq_abort[p] = LINK_FAIL_I[p];
          end
        end
      end
      ST_STORE: begin
        mem_we = 1'b1;
        mem_wa = state.d_addr;
        mem_wd = bin_bcd(state.rx_n + 9'h001);
        next_state.phase = ST_IDLE;
        next_state.exec[p] = 1'b0;
        next_state.seq_end[p] = !state.fail;
        next_state.seq_abort[p] = state.fail;
      end
    endcase
    // step error is sticky for the whole call
    if (|state.exec && LINK_STEP_ERR_I[p]) next_state.step_err[p] = 1'b1;
    // abort request ends the call at once
    if (|state.exec && state.abort_req[p]) begin
      next_state.exec[p] = 1'b0;
      next_state.seq_abort[p] = 1'b1;
      next_state.seq_end[p] = 1'b0;
      next_state.phase = ST_IDLE;
    end
    // call launch or rejection
    if (call) begin
      next_state.ctrl = PWDATA_I[15:0];
      if (call_ok) begin
        next_state.op_err = 1'b0;
        next_state.port = PWDATA_I[13];
        next_state.exec[PWDATA_I[13]] = 1'b1;
        next_state.step_err[PWDATA_I[13]] = 1'b0;
        next_state.seq_end[PWDATA_I[13]] = 1'b0;
        next_state.seq_abort[PWDATA_I[13]] = 1'b0;
        next_state.start[PWDATA_I[13]] = 1'b1;
        next_state.seq_num = 10'(bcd_bin({4'h0, PWDATA_I[11:0]}));
        next_state.s_addr = s_loc[12:0];
        next_state.d_addr = d_loc[12:0];
        next_state.tx_idx = 9'h000;
        next_state.rx_n = 9'h000;
        next_state.tx_left = s_none ? 9'h000 : 9'(cnt - 14'h0001);
        next_state.phase = (s_none || cnt == 14'h0001) ? ST_WAIT : ST_SEND;
      end else begin
        next_state.op_err = 1'b1;
      end
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state <= '0;
    end else if (CE_I) begin
      state <= next_state;
    end
  end

  // word memory, link write wins over a colliding apb write
  always_ff @(posedge CLK_I) begin
    if (!RST_I && CE_I && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // outputs
  assign PRDATA_O = state.prdata;
  assign PREADY_O = state.pready;
  assign PSLVERR_O = state.pslverr;
  assign LINK_START_O = state.start;
  assign LINK_SEQ_O = state.seq_num;
  assign LINK_TX_VALID_O = state.tx_valid;
  assign LINK_TX_DATA_O = state.tx_data;

  // ==========================================
  // checks
  default clocking cb @(posedge CLK_I iff CE_I);
  endclocking
  default disable iff (RST_I);

  sequence s_accept;
    call && call_ok;
  endsequence

  sequence s_launch;
    ##1 (|state.start) ##1 (state.start == 2'h0);
  endsequence

  a_bad_port: assert property (call && !p_ok |=> state.op_err && state.exec == $past(state.exec))
    else $error("bad port call not rejected");
  a_busy_reject: assert property (call && |state.exec |=> state.op_err && state.ctrl == $past(PWDATA_I[15:0]))
    else $error("call during run not rejected");
  a_send_const: assert property (call && state.s_op[`OP_CONST] && state.s_op[15:0] != 16'h0000 |=> state.op_err)
    else $error("nonzero send constant accepted");
  a_recv_const: assert property (call && state.d_op[`OP_CONST] |=> state.op_err && state.start == 2'h0)
    else $error("constant destination accepted");
  a_resv_dest: assert property (call && d_loc[13] && d_loc[12:0] >= `RSV_LO && d_loc[12:0] <= `RSV_HI |=> state.op_err)
    else $error("reserved destination accepted");
  a_call_start: assert property (s_accept |-> s_launch)
    else $error("start pulse missing");
  a_exec_set: assert property (s_accept |=> state.exec[state.port] && state.seq_num < 10'h3E8 && !state.op_err)
    else $error("execution flag not set");
  a_abort_clear: assert property (|state.exec && state.abort_req[state.port] |=> state.exec == 2'h0 && |state.seq_abort)
    else $error("abort did not clear execution");
  a_step_hold: assert property (state.step_err[0] && !s_accept |=> state.step_err[0])
    else $error("step error dropped");
  a_end_excl: assert property ($fell(state.exec[0]) |-> state.seq_end[0] != state.seq_abort[0])
    else $error("end and abort not exclusive");
  a_empty_nowr: assert property (state.phase == ST_WAIT && state.rx_n == 9'h000 && !LINK_RX_VALID_I[state.port] && !wr_ok |-> !mem_we)
    else $error("write with no receive data");
  a_count_wr: assert property (state.phase == ST_STORE |-> mem_we && mem_wa == state.d_addr && mem_wd != 16'h0000)
    else $error("count word not stored");
endmodule

// file: pscu_cfg.svh
`ifndef PSCU_CFG_SVH
`define PSCU_CFG_SVH

// ==========================================
// register byte addresses
`define A_CALL 16'h0000
`define A_SOP 16'h0004
`define A_DOP 16'h0008
`define A_STAT 16'h000C
`define A_ABORT 16'h0010
// ==========================================
// operand fields and limits
`define OP_CONST 17
`define OP_IND 16
`define PORT_A 4'h1
`define PORT_B 4'h2
`define MEM_WORDS 14'h2000
`define RSV_LO 13'h1800
`define RSV_HI 13'h19FF
`define CNT_MAX 14'h0100
`define RX_MAX 9'h0FF
`define ST_ERR 8
`endif

// file: pscu_pkg.sv
package pscu_pkg;
  // ==========================================
  // sequencer phases and block state
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_STORE} phase_type;
  typedef struct packed {
    phase_type phase;
    logic port;
    logic fail;
    logic [1:0] exec;
    logic [1:0] step_err;
    logic [1:0] seq_end;
    logic [1:0] seq_abort;
    logic [1:0] abort_req;
    logic op_err;
    logic [15:0] ctrl;
    logic [17:0] s_op;
    logic [17:0] d_op;
    logic [12:0] s_addr;
    logic [12:0] d_addr;
    logic [8:0] tx_left;
    logic [8:0] tx_idx;
    logic [8:0] rx_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] start;
    logic [9:0] seq_num;
    logic [1:0] tx_valid;
    logic [15:0] tx_data;
  } state_type;
endpackage

// file: link_partner_model.sv
// ==========================================
// far equipment on the link: answers each started sequence
module link_partner_model (
  input wire logic clk_i, // system clock
  input wire logic [1:0] start_i, // sequence start
  input wire logic [1:0] tx_valid_i, // send strobe
  input wire logic [15:0] tx_data_i, // send word
  input wire logic [15:0] word_i, // reply word
  input wire logic [7:0] wait_i, // reply delay
  input wire logic rx_n_i, // one reply word
  input wire logic step_i, // report a failed step
  input wire logic fail_i, // end the sequence in error
  output logic [1:0] rx_valid_o, // receive strobe
  output logic [15:0] rx_data_o, // receive word
  output logic [1:0] step_err_o, // step failed
  output logic [1:0] done_o, // normal end
  output logic [1:0] fail_o, // error end
  output logic [15:0] last_tx_o, // last send word
  output logic [7:0] n_tx_o // send words seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] p;
  // count send words of a call on either port
  always @(posedge clk_i) begin
    if (start_i != 2'b00) begin
      n_tx_o <= 8'h00;
    end else if (tx_valid_i != 2'b00) begin
      n_tx_o <= n_tx_o + 8'h01;
      last_tx_o <= tx_data_i;
    end
  end
  // reply on the started port; idle data never holds still
  initial begin
    rx_valid_o = 2'b00;
    step_err_o = 2'b00;
    done_o = 2'b00;
    fail_o = 2'b00;
    rx_data_o = 16'h5A5A;
    forever begin
      @(posedge clk_i);
      rx_data_o <= ~rx_data_o;
      if (start_i != 2'b00) begin
        p = start_i;
        repeat (wait_i) @(posedge clk_i);
        step_err_o <= p & {2{step_i}};
        @(posedge clk_i);
        step_err_o <= 2'b00;
        if (rx_n_i) begin
          rx_valid_o <= p;
          rx_data_o <= word_i;
          @(posedge clk_i);
          rx_valid_o <= 2'b00;
          rx_data_o <= ~word_i;
        end
        // the sequence ends either normally or in error, never both
        if (fail_i) begin
          fail_o <= p;
        end else begin
          done_o <= p;
        end
        @(posedge clk_i);
        done_o <= 2'b00;
        fail_o <= 2'b00;
      end
    end
  end
endmodule

// file: protocol_sequence_call_unit_bench.sv
module protocol_sequence_call_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, psel, pen, pwr, pready, pslverr, e, step, rxn, fl;
  logic [1:0] fail;
  logic [15:0] paddr, word, txd, rxd, last_tx, unit, val;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] start, txv, rxv, serr, done;
  logic [9:0] seq;
  logic [7:0] wt, ntx;
  int n_errors = 0, total_checks = 0, cyc = 0, u;
  int f[2][4];
  int f_err;
  int mem_m[int];
  logic [15:0] bc[6] = '{16'h3000, 16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h1000};
  logic [31:0] bs[6] = '{32'h10, 32'h20005, 32'h10, 32'h10, 32'h10, 32'h10030};
  logic [31:0] bd[6] = '{32'h20, 32'h20, 32'h20020, 32'h6144, 32'hA0, 32'h20};
  protocol_sequence_call_unit protocol_sequence_call_unit_i (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK_START_O(start),
    .LINK_SEQ_O(seq), .LINK_TX_VALID_O(txv), .LINK_TX_DATA_O(txd), .LINK_RX_VALID_I(rxv),
    .LINK_RX_DATA_I(rxd), .LINK_STEP_ERR_I(serr), .LINK_DONE_I(done), .LINK_FAIL_I(fail));
  link_partner_model link_partner_model_i (.clk_i(clk), .start_i(start), .tx_valid_i(txv),
    .tx_data_i(txd), .word_i(word), .wait_i(wt), .rx_n_i(rxn), .step_i(step), .fail_i(fl),
    .rx_valid_o(rxv), .rx_data_o(rxd), .step_err_o(serr), .done_o(done), .fail_o(fail),
    .last_tx_o(last_tx), .n_tx_o(ntx));
  // ==========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ==========================================
  // helpers
  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the cycle counter ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] st_m();
    logic [31:0] s;
    s = 32'h0;
    for (int p = 0; p < 2; p++)
      for (int b = 0; b < 4; b++)
        s[4 * p + b] = f[p][b][0];
    s[8] = f_err[0];
    return s;
  endfunction
  task automatic cs();
    apb(1'b0, 16'h000C, 32'h0);
    chk(r, st_m());
  endtask
  task automatic cm(input int i);
    apb(1'b0, 16'(32'h8000 + 4 * i), 32'h0);
    chk(r, 32'(mem_m[i]));
  endtask
  task automatic call(input logic [15:0] c, input logic [31:0] s, input logic [31:0] d);
    apb(1'b1, 16'h0004, s);
    apb(1'b1, 16'h0008, d);
    apb(1'b1, 16'h0000, {16'h0000, c});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, 16'h000C, 32'h0);
      n++;
    end while ((r[0] | r[4]) !== 1'b0 && n < 100);
  endtask
  // ==========================================
  // main sequence
  initial begin
    {rst, psel, pen, pwr, step, rxn, fl} = 7'h40;
    {paddr, word, pwdata} = '0;
    wt = 8'd4;
    f = '{default: 0};
    f_err = 0;
    void'($urandom(3283));
    u = $urandom % 32;
    unit = 16'((u / 10) * 16 + u % 10);
    for (int k = 0; k < 4; k++) val[4 * k +: 4] = 4'($urandom % 10);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cs();
    apb(1'b0, 16'h0014, 32'h0);
    chk({31'h0, e}, 32'h1);
    mem_m[10] = 2;
    mem_m[11] = unit;
    mem_m[20] = 16'hAAAA;
    mem_m[30] = 16'h00AB;
    mem_m[40] = 16'h1234;
    foreach (mem_m[i]) apb(1'b1, 16'(32'h8000 + 4 * i), 32'(mem_m[i]));
    // read sequence on port A with one reply word
    word <= val;
    rxn <= 1'b1;
    call(16'h1000, 32'h10, 32'h20);
    chk({20'h0, seq, start}, 32'h1);
    wait_idle();
    chk({8'h00, ntx, last_tx}, {16'h0001, unit});
    mem_m[20] = 2;
    mem_m[21] = val;
    f[0][2] = 1;
    cm(20);
    cm(21);
    cs();
    // port B, nothing sent or received, a failed step, ends in error
    rxn <= 1'b0;
    step <= 1'b1;
    fl <= 1'b1;
    call(16'h2350, 32'h20000, 32'h40);
    chk({20'h0, seq, start}, {20'h0, 10'd350, 2'b10});
    wait_idle();
    f[1][1] = 1;
    f[1][3] = 1;
    cm(40);
    cs();
    // refused calls set the error flag, start nothing and leave memory untouched
    step <= 1'b0;
    fl <= 1'b0;
    f_err = 1;
    for (int k = 0; k < 6; k++) begin
      call(bc[k], bs[k], bd[k]);
      chk({30'h0, start}, 32'h0);
      cs();
    end
    cm(20);
    // busy port A refuses a second call on port B, then abort request
    wt <= 8'd60;
    call(16'h1000, 32'h10, 32'h20);
    f[0] = '{1, 0, 0, 0};
    f_err = 0;
    cs();
    call(16'h2000, 32'h20000, 32'h40);
    chk({30'h0, start}, 32'h0);
    f_err = 1;
    apb(1'b1, 16'h0010, 32'h1);
    f[0][0] = 0;
    f[0][3] = 1;
    cs();
    apb(1'b1, 16'h0010, 32'h0);
    repeat (80) @(posedge clk);
    tally_and_finish();
  end
endmodule
